// >>> include/mia_pkg.sv
// shared constants and types of the interrupt arbiter
package mia_pkg;
    // source counts and ordering (index 0 = highest priority)
    localparam int          MIA_NEXT      = 5;
    localparam int          MIA_NINT      = 9;
    localparam int          MIA_NSRC      = 14;
    localparam int          MIA_IDX_W     = 4;
    // register offsets
    localparam logic [7:0]  MIA_OFS_FLAGS_A = 8'h00;
    localparam logic [7:0]  MIA_OFS_FLAGS_B = 8'h01;
    localparam logic [7:0]  MIA_OFS_EN_A    = 8'h02;
    localparam logic [7:0]  MIA_OFS_EN_B    = 8'h03;
    localparam logic [7:0]  MIA_OFS_EDGE    = 8'h04;
    localparam logic [7:0]  MIA_OFS_PF_ONE  = 8'h05;
    localparam logic [7:0]  MIA_OFS_PF_TWO  = 8'h06;
    localparam logic [7:0]  MIA_OFS_PF_B    = 8'h07;
    localparam logic [7:0]  MIA_OFS_ECE     = 8'h08;
    localparam logic [7:0]  MIA_OFS_STATUS  = 8'h09;
    // reset values
    localparam logic [7:0]  MIA_RST_BYTE  = 8'h00;
    localparam logic [13:0] MIA_RST_FLAGS = 14'h0000;
    // field positions
    localparam int          MIA_B_SRC0    = 0;
    localparam int          MIA_B_SRC1    = 1;
    localparam int          MIA_B_EC      = 2;
    localparam int          MIA_B_SRC3    = 3;
    localparam int          MIA_B_SRC4    = 4;
    localparam int          MIA_B_INT0    = 5;
    localparam int          MIA_B_FLAGS_B = 8;
    localparam int          MIA_W_FLAGS_B = 6;
    localparam int          MIA_CE_LO     = 0;
    localparam int          MIA_CE_HI     = 1;
    localparam int          MIA_CE_SRC    = 2;
    localparam int          MIA_CCR_I     = 7;
    // exception entry timing in states
    localparam int          MIA_STACK_STATES = 4;
    localparam int          MIA_WORD_STATES  = MIA_STACK_STATES / 2;
    localparam int          MIA_VEC_STATES   = 2;
    localparam logic        MIA_PH_LAST      = 1'(MIA_WORD_STATES - 1);
    // word access: lowest address bit always zero
    localparam logic [15:0] MIA_WORD_ALIGN = 16'hFFFE;
    localparam logic [15:0] MIA_WORD_BYTES = 16'h0002;
    // vector number of each source, in priority order
    localparam logic [4:0]  MIA_VEC_NUM [MIA_NSRC] = '{
        5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
        5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10,
        5'h12, 5'h13, 5'h14};

    typedef enum logic [2:0] {
        MIA_IDLE    = 3'b000,
        MIA_WAIT    = 3'b001,
        MIA_STK_PC  = 3'b011,
        MIA_STK_CCR = 3'b010,
        MIA_VEC     = 3'b110,
        MIA_JUMP    = 3'b111
    } mia_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        we;
        logic        re;
    } mia_mem_req_t;
endpackage

// >>> core/mia_arbiter.sv
// interrupt arbiter: request flags, enables, edge detect and exception entry
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mia_arbiter
    import mia_pkg::*;
#(
    parameter int INT_SRCS = 9
) (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [7:0]                reg_rdata,
    input  wire logic [INT_SRCS-1:0]  int_req,
    input  wire logic [3:0]           ext_pin_n,
    input  wire logic                 event_counter_irq_pin,
    input  wire logic                 counter_modulated_signal,
    input  wire logic [7:0]           condition_code_reg,
    input  wire logic                 instr_done,
    input  wire logic [15:0]          pc_next,
    input  wire logic [15:0]          sp,
    output mia_pkg::mia_mem_req_t     mem_req,
    input  wire logic [15:0]          mem_rdata,
    output logic                      set_mask,
    output logic                      pc_load,
    output logic [15:0]               pc_target,
    output logic                      irq_pending,
    input  wire logic                 rte_load,
    input  wire logic [15:0]          rte_word,
    output logic [7:0]                ccr_restore
);
    import mia_pkg::*;

    generate
        if (INT_SRCS != MIA_NINT) begin : g_bad_count
            $error("mia_arbiter serves exactly nine internal sources");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers
    logic [7:0]       enable_bits_a;
    logic [7:0]       enable_bits_b;
    logic [7:0]       edge_select_reg;
    logic [7:0]       pin_function_reg_one;
    logic [7:0]       pin_function_reg_two;
    logic [7:0]       pin_function_reg_b;
    logic [7:0]       event_counter_edge_reg;
    logic [13:0]      flags;
    logic [13:0]      en_all;
    logic [13:0]      raw_evt;
    logic [13:0]      set_evt;
    logic [13:0]      clr;
    logic [13:0]      pend;
    logic             mask_bit;
    mia_state_t       state;
    mia_state_t       next_state;
    logic             phase;
    logic [MIA_IDX_W-1:0] sel_idx;
    logic [4:0]       sel_vec;
    logic [15:0]      stk_pc;
    logic [7:0]       stk_ccr;

    assign mask_bit = condition_code_reg[MIA_CCR_I];

    // software writable settings
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            enable_bits_a          <= MIA_RST_BYTE;
            enable_bits_b          <= MIA_RST_BYTE;
            edge_select_reg        <= MIA_RST_BYTE;
            pin_function_reg_one   <= MIA_RST_BYTE;
            pin_function_reg_two   <= MIA_RST_BYTE;
            pin_function_reg_b     <= MIA_RST_BYTE;
            event_counter_edge_reg <= MIA_RST_BYTE;
        end else if (reg_wr) begin
            unique case (reg_addr)
                MIA_OFS_EN_A:   enable_bits_a          <= reg_wdata;
                MIA_OFS_EN_B:   enable_bits_b          <= reg_wdata;
                MIA_OFS_EDGE:   edge_select_reg        <= reg_wdata;
                MIA_OFS_PF_ONE: pin_function_reg_one   <= reg_wdata;
                MIA_OFS_PF_TWO: pin_function_reg_two   <= reg_wdata;
                MIA_OFS_PF_B:   pin_function_reg_b     <= reg_wdata;
                MIA_OFS_ECE:    event_counter_edge_reg <= reg_wdata;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // external edge detection
    logic [3:0] ext_func;
    logic [3:0] ext_esel;
    logic [3:0] ext_eff;
    logic [3:0] ext_prev;
    logic [3:0] ext_evt;
    logic       ec_sig;
    logic       ec_prev;
    logic       ec_rise;
    logic       ec_fall;
    logic       ec_evt;

    // pin index 0..3 serves sources 0, 1, 3, 4
    assign ext_func = {pin_function_reg_one[MIA_B_SRC4], pin_function_reg_one[MIA_B_SRC3],
                       pin_function_reg_b[MIA_B_SRC0], pin_function_reg_two[MIA_B_SRC0]};
    assign ext_esel = {edge_select_reg[MIA_B_SRC4], edge_select_reg[MIA_B_SRC3],
                       edge_select_reg[MIA_B_SRC1], edge_select_reg[MIA_B_SRC0]};
    // a pin not in interrupt function looks high, so switching it with the pin low is an edge
    assign ext_eff  = (ext_func & ext_pin_n) | ~ext_func;
    // edge select zero falling, one rising
    assign ext_evt  = (ext_esel & ~ext_prev & ext_eff) | (~ext_esel & ext_prev & ~ext_eff);

    // counter source: pin or modulated signal, a change of source may itself be an edge
    assign ec_sig  = event_counter_edge_reg[MIA_CE_SRC] ? counter_modulated_signal
                                                         : event_counter_irq_pin;
    assign ec_rise = ~ec_prev & ec_sig;
    assign ec_fall = ec_prev & ~ec_sig;
    always_comb begin
        if (event_counter_edge_reg[MIA_CE_HI]) begin
            ec_evt = ec_rise | ec_fall;
        end else if (event_counter_edge_reg[MIA_CE_LO]) begin
            ec_evt = ec_rise;
        end else begin
            ec_evt = ec_fall;
        end
    end

    // previous levels for edge detection
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ext_prev <= 4'hF;
            ec_prev  <= 1'b1;
        end else begin
            ext_prev <= ext_eff;
            ec_prev  <= ec_sig;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // request flags
    assign en_all  = {enable_bits_b[MIA_W_FLAGS_B-1:0], enable_bits_a};
    assign raw_evt = {int_req, ext_evt[3], ext_evt[2], ec_evt, ext_evt[1], ext_evt[0]};
    assign set_evt = raw_evt & en_all;
    assign pend    = flags & en_all;

    // only a written zero over a set flag clears it
    always_comb begin
        clr = MIA_RST_FLAGS;
        if (reg_wr && reg_addr == MIA_OFS_FLAGS_A) begin
            clr[MIA_B_FLAGS_B-1:0] = ~reg_wdata & flags[MIA_B_FLAGS_B-1:0];
        end
        if (reg_wr && reg_addr == MIA_OFS_FLAGS_B) begin
            clr[MIA_NSRC-1:MIA_B_FLAGS_B] = ~reg_wdata[MIA_W_FLAGS_B-1:0]
                                          & flags[MIA_NSRC-1:MIA_B_FLAGS_B];
        end
    end

    // set wins over a colliding clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flags <= MIA_RST_FLAGS;
        end else begin
            flags <= (flags & ~clr) | set_evt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // priority select: lowest index wins
    function automatic logic [MIA_IDX_W-1:0] mia_first(input logic [13:0] p);
        logic [MIA_IDX_W-1:0] idx;
        idx = '0;
        for (int i = MIA_NSRC - 1; i >= 0; i--) begin
            if (p[i]) begin
                idx = MIA_IDX_W'(i);
            end
        end
        return idx;
    endfunction

    assign irq_pending = |pend;

    ////////////////////////////////////////////////////////////////////////////
    // exception entry sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            MIA_IDLE: begin
                if (|pend && !mask_bit) begin
                    next_state = MIA_WAIT;
                end
            end
            MIA_WAIT: begin
                if (instr_done) begin
                    next_state = MIA_STK_PC;
                end
            end
            MIA_STK_PC: begin
                if (phase == MIA_PH_LAST) begin
                    next_state = MIA_STK_CCR;
                end
            end
            MIA_STK_CCR: begin
                if (phase == MIA_PH_LAST) begin
                    next_state = MIA_VEC;
                end
            end
            MIA_VEC: begin
                if (phase == MIA_PH_LAST) begin
                    next_state = MIA_JUMP;
                end
            end
            MIA_JUMP: next_state = MIA_IDLE;
            // unused codes fall back to idle
            default:  next_state = MIA_IDLE;
        endcase
    end

    // state and phase within a two state bus cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= MIA_IDLE;
            phase <= 1'b0;
        end else begin
            state <= next_state;
            phase <= (next_state == state) ? ~phase : 1'b0;
        end
    end

    // latch the selected source on acceptance
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sel_idx <= '0;
            sel_vec <= '0;
        end else if (state == MIA_IDLE && next_state == MIA_WAIT) begin
            sel_idx <= mia_first(pend);
            sel_vec <= MIA_VEC_NUM[mia_first(pend)];
        end
    end

    // return context captured when the instruction completes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stk_pc  <= '0;
            stk_ccr <= MIA_RST_BYTE;
        end else if (state == MIA_WAIT && instr_done) begin
            stk_pc  <= pc_next;
            stk_ccr <= condition_code_reg;
        end
    end

    // registered memory requests for stacking and vector fetch
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mem_req <= '0;
        end else begin
            mem_req.we <= (next_state == MIA_STK_PC) || (next_state == MIA_STK_CCR);
            mem_req.re <= (next_state == MIA_VEC);
            unique case (next_state)
                MIA_STK_PC: begin
                    mem_req.addr  <= (sp - MIA_WORD_BYTES) & MIA_WORD_ALIGN;
                    mem_req.wdata <= (state == MIA_WAIT) ? pc_next : stk_pc;
                end
                MIA_STK_CCR: begin
                    mem_req.addr  <= (sp - MIA_WORD_BYTES - MIA_WORD_BYTES) & MIA_WORD_ALIGN;
                    mem_req.wdata <= {stk_ccr, stk_ccr};
                end
                MIA_VEC: begin
                    mem_req.addr  <= {10'h000, sel_vec, 1'b0} & MIA_WORD_ALIGN;
                    mem_req.wdata <= '0;
                end
                default: begin
                    mem_req.addr  <= '0;
                    mem_req.wdata <= '0;
                end
            endcase
        end
    end

    // mask set, handler jump
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            set_mask  <= 1'b0;
            pc_load   <= 1'b0;
            pc_target <= '0;
        end else begin
            set_mask <= (state == MIA_WAIT) && instr_done;
            pc_load  <= (next_state == MIA_JUMP);
            if (state == MIA_VEC && phase == MIA_PH_LAST) begin
                pc_target <= mem_rdata & MIA_WORD_ALIGN;
            end
        end
    end

    // return: even address byte is the CONDITION_CODE_REG, odd byte ignored
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ccr_restore <= MIA_RST_BYTE;
        end else if (rte_load) begin
            ccr_restore <= rte_word[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read port, data one cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            reg_rdata <= MIA_RST_BYTE;
        end else if (reg_rd) begin
            unique case (reg_addr)
                MIA_OFS_FLAGS_A: reg_rdata <= flags[MIA_B_FLAGS_B-1:0];
                MIA_OFS_FLAGS_B: reg_rdata <= {2'b00, flags[MIA_NSRC-1:MIA_B_FLAGS_B]};
                MIA_OFS_EN_A:    reg_rdata <= enable_bits_a;
                MIA_OFS_EN_B:    reg_rdata <= enable_bits_b;
                MIA_OFS_EDGE:    reg_rdata <= edge_select_reg;
                MIA_OFS_PF_ONE:  reg_rdata <= pin_function_reg_one;
                MIA_OFS_PF_TWO:  reg_rdata <= pin_function_reg_two;
                MIA_OFS_PF_B:    reg_rdata <= pin_function_reg_b;
                MIA_OFS_ECE:     reg_rdata <= event_counter_edge_reg;
                MIA_OFS_STATUS:  reg_rdata <= {state, sel_vec};
                default:         reg_rdata <= MIA_RST_BYTE;
            endcase
        end else begin
            reg_rdata <= MIA_RST_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_stacking;
        mem_req.we [*4];
    endsequence

    sequence s_vec_fetch;
        mem_req.re [*2];
    endsequence

    chk_flag_set: assert property (
        (|set_evt) |=> ((flags & $past(set_evt)) == $past(set_evt)))
        else $error("enabled request did not set its flag");

    chk_write_one_keeps: assert property (
        (reg_wr && reg_addr == MIA_OFS_FLAGS_A && reg_wdata == 8'hFF)
        |=> (flags[7:0] == ($past(flags[7:0]) | $past(set_evt[7:0]))))
        else $error("writing ones changed flags");

    chk_mask_blocks: assert property (
        (state == MIA_IDLE && mask_bit) |=> (state == MIA_IDLE))
        else $error("request accepted while masked");

    chk_accept_highest: assert property (
        (state == MIA_IDLE && |pend && !mask_bit)
        |=> (state == MIA_WAIT && sel_idx == mia_first($past(pend))))
        else $error("wrong request selected");

    chk_entry_timing: assert property (
        (state == MIA_WAIT && instr_done) |=> s_stacking ##1 s_vec_fetch ##1 pc_load)
        else $error("exception entry timing wrong");

    chk_mask_set: assert property (
        (state == MIA_WAIT && instr_done) |=> set_mask ##1 !set_mask)
        else $error("mask not set on entry");

    chk_stacked_pc: assert property (
        (state == MIA_WAIT && instr_done) |=> (mem_req.wdata == $past(pc_next)))
        else $error("stacked pc is not the return address");

    chk_word_even: assert property (
        (mem_req.we || mem_req.re) |-> !mem_req.addr[0])
        else $error("odd word address");

    chk_ccr_word: assert property (
        (mem_req.we && state == MIA_STK_CCR) |-> (mem_req.wdata[15:8] == mem_req.wdata[7:0]))
        else $error("ccr not stacked in both bytes");

    chk_vec_addr: assert property (
        mem_req.re |-> (mem_req.addr == {10'h000, sel_vec, 1'b0}))
        else $error("vector address wrong");

    chk_pin_switch: assert property (
        ($rose(ext_func[0]) && !ext_pin_n[0] && !ext_esel[0] && en_all[MIA_B_SRC0])
        |=> flags[MIA_B_SRC0])
        else $error("function switch with low pin did not set flag");
endmodule
`default_nettype wire

// >>> verif/mia_cpu_model.sv
// behavioural cpu core standing at the far side of the interrupt arbiter
`timescale 1ns/1ps
`default_nettype none
module mia_cpu_model
    import mia_pkg::*;
#(
    parameter logic [15:0] HANDLER_BASE = 16'hA001,
    parameter logic [15:0] SP_INIT      = 16'hFF80
) (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  set_mask,
    input  wire mia_pkg::mia_mem_req_t mem_req,
    input  wire logic                  pc_load,
    input  wire logic [15:0]           pc_target,
    input  wire logic                  ccr_wr,
    input  wire logic [7:0]            ccr_val,
    input  wire logic                  slow,
    output logic [7:0]                 condition_code_reg,
    output logic                       instr_done,
    output logic [15:0]                pc_next,
    output logic [15:0]                sp,
    output logic [15:0]                mem_rdata
);
    logic [3:0]  state_left;
    logic [15:0] idle_pat;
    ////////////////////////////////////////////////////////////////////////////
    // instruction length of one state or thirteen
    always_ff @(posedge clk) begin
        if (sys_rst || state_left == 4'h0) begin
            state_left <= (slow && !sys_rst) ? 4'hC : 4'h0;
        end else begin
            state_left <= state_left - 4'h1;
        end
    end
    assign instr_done = (state_left == 4'h0);
    // mask bit set on entry, otherwise software writes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            condition_code_reg <= 8'h80;
        end else if (set_mask) begin
            condition_code_reg[MIA_CCR_I] <= 1'b1;
        end else if (ccr_wr) begin
            condition_code_reg <= ccr_val;
        end
    end
    // jump to handler; released read bus shows a toggling pattern
    always_ff @(posedge clk) begin
        pc_next  <= sys_rst ? 16'h0100 : (pc_load ? pc_target : pc_next);
        idle_pat <= sys_rst ? 16'h5AA5 : ~idle_pat;
    end
    // even stack pointer; odd handler word tests bit zero forcing
    assign sp        = SP_INIT;
    assign mem_rdata = mem_req.re ? (HANDLER_BASE ^ {mem_req.addr[11:0], 4'h0}) : idle_pat;
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench of the interrupt arbiter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import mia_pkg::*;
    localparam logic [15:0] HBASE = 16'hA001;
    logic         clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, ccr_wr = 1'b0, slow = 1'b0;
    logic         event_counter_irq_pin = 1'b0, counter_modulated_signal = 1'b1, rte_load = 1'b0;
    logic         instr_done, set_mask, pc_load, irq_pending;
    logic [3:0]   ext_pin_n = 4'hF;
    logic [7:0]   reg_addr = 8'h00, reg_wdata = 8'h00, ccr_val = 8'h00, reg_rdata, condition_code_reg, ccr_restore;
    logic [8:0]   int_req = 9'h000, r;
    logic [13:0]  exp14;
    logic [15:0]  rte_word = 16'h0000, pc_next, sp, mem_rdata, pc_target;
    mia_mem_req_t mem_req;
    integer       seed = 32'hD8A44DB8;
    int           n_fail = 0, comparisons = 0, idx;
    ////////////////////////////////////////////////////////////////////////////
    // clock and the two parties
    always #10 clk = ~clk;
    mia_arbiter #(.INT_SRCS(9)) dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .int_req,
        .ext_pin_n, .event_counter_irq_pin, .counter_modulated_signal, .condition_code_reg, .instr_done, .pc_next,
        .sp, .mem_req, .mem_rdata, .set_mask, .pc_load, .pc_target, .irq_pending, .rte_load, .rte_word, .ccr_restore);
    mia_cpu_model #(.HANDLER_BASE(HBASE)) cpu (.clk, .sys_rst, .set_mask, .mem_req, .pc_load, .pc_target, .ccr_wr,
        .ccr_val, .slow, .condition_code_reg, .instr_done, .pc_next, .sp, .mem_rdata);
    ////////////////////////////////////////////////////////////////////////////
    // compare, report and finish
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // register bus cycles and cpu-side helpers
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk(40'(reg_rdata), 40'(e));
    endtask
    task automatic ccr_set(input logic [7:0] v);
        ccr_val <= v;
        ccr_wr  <= 1'b1;
        @(posedge clk);
        ccr_wr  <= 1'b0;
        @(posedge clk);
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // exception entry of priority index i, checked phase by phase
    task automatic entry(input int i);
        logic [15:0] va;
        logic [15:0] pcs;
        logic [7:0]  cc;
        int          n;
        va  = {10'h000, 5'(i < 5 ? 4 + i : (i < 11 ? 6 + i : 7 + i)), 1'b0};
        pcs = pc_next;
        cc  = condition_code_reg;
        n   = 0;
        do begin
            step(1);
            n++;
        end while (set_mask !== 1'b1 && n < 40);
        chk(40'(n < 40), 40'h1);
        chk(40'(mem_req), 40'({(sp - 16'h0002) & 16'hFFFE, pcs, 2'b10}));
        step(2);
        chk(40'(mem_req), 40'({(sp - 16'h0004) & 16'hFFFE, cc, cc, 2'b10}));
        step(2);
        chk(40'({mem_req.addr, mem_req.we, mem_req.re}), 40'({va, 2'b01}));
        step(2);
        chk(40'({pc_load, pc_target}), 40'({1'b1, (HBASE ^ {va[11:0], 4'h0}) & 16'hFFFE}));
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        for (int a = 0; a < 11; a++) begin
            rd(8'(a), 8'h00);
        end
        wr(MIA_OFS_EN_A, 8'hFF);
        wr(MIA_OFS_EN_B, 8'h3E);
        wr(MIA_OFS_PF_TWO, 8'h01);
        wr(MIA_OFS_EDGE, 8'h02);
        wr(MIA_OFS_PF_B, 8'h01);
        ext_pin_n <= 4'b1000;
        repeat (2) @(posedge clk);
        rd(MIA_OFS_FLAGS_A, 8'h01);
        ext_pin_n <= 4'b1010;
        wr(MIA_OFS_PF_ONE, 8'h08);
        wr(MIA_OFS_ECE, 8'h06);
        wr(MIA_OFS_ECE, 8'h02);
        repeat (2) @(posedge clk);
        rd(MIA_OFS_FLAGS_A, 8'h0F);
        r = 9'($random(seed)) | 9'h100;
        int_req <= r;
        @(posedge clk);
        int_req <= 9'h000;
        repeat (2) @(posedge clk);
        exp14 = {r[8:4], 1'b0, r[2:0], 5'b01111};
        rd(MIA_OFS_FLAGS_A, exp14[7:0]);
        rd(MIA_OFS_FLAGS_B, {2'b00, exp14[13:8]});
        wr(MIA_OFS_FLAGS_A, 8'hFF);
        rd(MIA_OFS_FLAGS_A, exp14[7:0]);
        repeat (20) begin
            step(1);
            chk(40'(set_mask), 40'h0);
        end
        chk(40'(irq_pending), 40'h1);
        while (exp14 != 14'h0000) begin
            for (int i = 13; i >= 0; i--) begin
                if (exp14[i]) idx = i;
            end
            slow <= ~slow;
            ccr_set({1'b0, 7'($random(seed))});
            entry(idx);
            step(1);
            chk(40'(condition_code_reg[MIA_CCR_I]), 40'h1);
            if (idx < 8) begin
                wr(MIA_OFS_FLAGS_A, ~(8'h01 << idx));
            end else begin
                wr(MIA_OFS_FLAGS_B, ~(8'h01 << (idx - 8)));
            end
            exp14[idx] = 1'b0;
        end
        step(1);
        chk(40'(irq_pending), 40'h0);
        rte_word <= 16'($random(seed));
        rte_load <= 1'b1;
        @(posedge clk);
        rte_load <= 1'b0;
        #1;
        chk(40'(ccr_restore), 40'(rte_word[15:8]));
        conclude();
    end
    // hang guard
    initial begin
        #200000;
        n_fail++;
        conclude();
    end
endmodule
`default_nettype wire
